// [rtl/cwq_consts.svh]
`ifndef CWQ_CONSTS_SVH
`define CWQ_CONSTS_SVH
// Register offsets on the serial control port
`define CWQ_OFS_CH_MASK   7'h04
`define CWQ_OFS_PHASE_SEL 7'h2D
// Field layout of the phase select register
`define CWQ_CODE_MSB      3
`define CWQ_EN_BIT        4
// Reset values
`define CWQ_MASK_RST      8'hFF
`define CWQ_CODE_RST      4'h0
// Serial frame: one direction bit, seven address bits, eight data bits
`define CWQ_FRAME_BITS    4'hF
`define CWQ_CMD_LAST      4'h7
// Divider state held while the array reset is high, and the first state after it
`define CWQ_DIV_HOLD_CNT  2'h3
`define CWQ_DIV_FIRST_CNT 2'h0
`endif

// [rtl/cwq_pkg.sv]
package cwq_pkg;
	// Serial port states, Gray along idle, command, data
	typedef enum logic [1:0] {
		SP_IDLE = 2'h0,
		SP_CMD  = 2'h1,
		SP_DATA = 2'h3
	} cwq_sp_e;

	typedef logic [1:0] cwq_cnt_t;

	// In-phase is high in counts 0 and 1
	function automatic logic cwq_lo_i(input cwq_cnt_t c);
		return (c == 2'h0) || (c == 2'h1);
	endfunction : cwq_lo_i

	// Quadrature is the same decode one count later
	function automatic logic cwq_lo_q(input cwq_cnt_t c);
		return (c == 2'h1) || (c == 2'h2);
	endfunction : cwq_lo_q
endpackage : cwq_pkg

// [rtl/cwq_divider.sv]
`timescale 1ns/1ps
`include "cwq_consts.svh"
module cwq_divider (
	input  wire logic          i_clk,
	input  wire logic          i_rst,
	input  wire logic          i_osc_rise,
	input  wire logic          i_hold,
	output cwq_pkg::cwq_cnt_t  o_cnt,
	output logic               o_lo_i,
	output logic               o_lo_q
);
	import cwq_pkg::*;

	cwq_cnt_t cnt_r;   // Divide-by-four state
	cwq_cnt_t cnt_nxt; // State after the next oscillator edge
	logic     lo_i_r;  // Retimed in-phase output
	logic     lo_q_r;  // Retimed quadrature output

	assign cnt_nxt = cnt_r + 2'h1;

	// two-bit counter
	// Advances once per oscillator rise, held while reset pin high
	// power-up quadrant arbitrary
	// System reset loads the same held count as the shared reset pin does
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt_r <= `CWQ_DIV_HOLD_CNT;
		end else if (i_hold) begin
			cnt_r <= `CWQ_DIV_HOLD_CNT;
		end else if (i_osc_rise) begin
			cnt_r <= cnt_nxt;
		end
	end

	// retimed final flops
	// Outputs load only on the oscillator edge, never from counter glitches
	always_ff @(posedge i_clk) begin
		if (i_rst || i_hold) begin
			lo_i_r <= 1'b0;
			lo_q_r <= 1'b0;
		end else if (i_osc_rise) begin
			lo_i_r <= cwq_lo_i(cnt_nxt);
			lo_q_r <= cwq_lo_q(cnt_nxt);
		end
	end

	assign o_cnt  = cnt_r;
	assign o_lo_i = lo_i_r;
	assign o_lo_q = lo_q_r;
endmodule : cwq_divider

// [rtl/cwq_phase_select.sv]
`timescale 1ns/1ps
`include "cwq_consts.svh"
// Operation
// - Divide oscillator by four for I/Q
// - I/Q duty fixed at half period
// - Output flops retimed by oscillator edge
// - Sixteen 22.5 degree states via serial
// - Code bits 3:0 select rotation
// - Equal codes give in-phase channels
// - One code step leads 22.5 degrees
// - Reset pin forces dividers known state
// - Resume on next oscillator rise
// - Unreset divider may start any quadrant
module cwq_phase_select (
	input  wire logic        I_CLOCK,
	input  wire logic        I_SYS_RST,
	input  wire logic        I_QUAD_RATE_OSC_IN,
	input  wire logic        I_DIV_RESET,
	input  wire logic        I_SCLK,
	input  wire logic        I_CS_N,
	input  wire logic        I_SDIO,
	output logic             O_SDIO,
	output logic             O_SDIO_OE,
	output logic             O_LO_I,
	output logic             O_LO_Q,
	output logic [31:0]      O_CH_CODE,
	output logic [7:0]       O_CH_EN
);
	import cwq_pkg::*;

	localparam int NCH = 8; // Channels per device

	// Pin synchronisers: osc, reset pin, sclk, cs_n, sdio
	logic [4:0]  s1_r;        // First stage, read by s2 only
	logic [4:0]  s2_r;        // Second stage, safe to use
	logic [2:0]  s3_r;        // Previous osc, sclk, cs_n
	logic        osc_rise;    // Oscillator rising edge seen
	logic        div_hold;    // Array reset level
	logic        sclk_rise;   // Serial clock rising
	logic        sclk_fall;   // Serial clock falling
	logic        cs_act;      // Chip select active

	// Serial port
	cwq_sp_e     sp_r;        // Port state
	logic [3:0]  bit_r;       // Bits taken in this frame
	logic [14:0] sh_r;        // Incoming shift register
	logic [7:0]  rd_sh_r;     // Outgoing read data
	logic        rd_r;        // Frame is a read
	logic        wr_stb;      // Last data bit taken on a write
	logic [6:0]  wr_addr;     // Address of the write
	logic [7:0]  wr_data;     // Data of the write
	logic [6:0]  rd_addr;     // Address as its last bit arrives
	logic [7:0]  rd_val;      // Value for the addressed register

	// Registers
	logic [7:0]  mask_r;      // Channels a phase write goes to
	logic [3:0]  code_r [NCH];// Per-channel phase code
	logic [NCH-1:0] en_r;     // Per-channel enable

	// Divider
	cwq_cnt_t    cnt;
	logic        lo_i;
	logic        lo_q;

	// Two flops before any pin is looked at
	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			// Idle pin levels, so no false edge or hold follows reset
			s1_r <= 5'h08;
			s2_r <= 5'h08;
			s3_r <= 3'h4;
		end else begin
			s1_r <= {I_SDIO, I_CS_N, I_SCLK, I_DIV_RESET, I_QUAD_RATE_OSC_IN};
			s2_r <= s1_r;
			s3_r <= {s2_r[3], s2_r[2], s2_r[0]};
		end
	end

	assign osc_rise  = s2_r[0] & ~s3_r[0];
	assign div_hold  = s2_r[1];
	assign sclk_rise = s2_r[2] & ~s3_r[1];
	assign sclk_fall = ~s2_r[2] & s3_r[1];
	assign cs_act    = ~s2_r[3];

	cwq_divider u_div (
		.i_clk      (I_CLOCK),
		.i_rst      (I_SYS_RST),
		.i_osc_rise (osc_rise),
		.i_hold     (div_hold),
		.o_cnt      (cnt),
		.o_lo_i     (lo_i),
		.o_lo_q     (lo_q)
	);

	// Serial frame: direction, address, data, MSB first
	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST || !cs_act) begin
			// Deselect aborts any partial frame
			sp_r  <= SP_IDLE;
			bit_r <= 4'h0;
			sh_r  <= 15'h0000;
			rd_r  <= 1'b0;
		end else if (sclk_rise) begin
			sh_r  <= {sh_r[13:0], s2_r[4]};
			bit_r <= bit_r + 4'h1;
			case (sp_r)
				SP_IDLE: begin
					sp_r <= SP_CMD;
					rd_r <= s2_r[4];
				end
				SP_CMD: begin
					if (bit_r == `CWQ_CMD_LAST) begin
						sp_r <= SP_DATA;
					end
				end
				SP_DATA: begin
					// Further clocks after a frame start a new one; bit_r wraps to 0
					if (bit_r == `CWQ_FRAME_BITS) begin
						sp_r <= SP_IDLE;
					end
				end
				default: begin
					sp_r <= SP_IDLE;
				end
			endcase
		end
	end

	assign wr_stb  = sclk_rise && cs_act && (sp_r == SP_DATA) && !rd_r
		&& (bit_r == `CWQ_FRAME_BITS);
	assign wr_addr = sh_r[13:7];
	// Direction bit sits above; the address LSB is still on the pin
	assign rd_addr = {sh_r[5:0], s2_r[4]};
	assign wr_data = {sh_r[6:0], s2_r[4]};

	// Read mux; phase register shows lowest masked channel
	always_comb begin
		rd_val = 8'h00;
		if (rd_addr == `CWQ_OFS_CH_MASK) begin
			rd_val = mask_r;
		end else if (rd_addr == `CWQ_OFS_PHASE_SEL) begin
			for (int k = NCH - 1; k >= 0; k--) begin
				if (mask_r[k]) begin
					rd_val = {3'h0, en_r[k], code_r[k]};
				end
			end
		end
	end

	// Read data loads after the address, shifts on falling clock
	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST || !cs_act) begin
			rd_sh_r   <= 8'h00;
			O_SDIO_OE <= 1'b0;
		end else if (sclk_rise && sp_r == SP_CMD && bit_r == `CWQ_CMD_LAST) begin
			rd_sh_r   <= rd_val;
			O_SDIO_OE <= rd_r;
		end else if (sclk_fall && O_SDIO_OE && bit_r != 4'h8) begin
			rd_sh_r <= {rd_sh_r[6:0], 1'b0};
		end
	end

	assign O_SDIO = rd_sh_r[7];

	// Channel mask register
	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			mask_r <= `CWQ_MASK_RST;
		end else if (wr_stb && wr_addr == `CWQ_OFS_CH_MASK) begin
			mask_r <= wr_data;
		end
	end

	// sixteen phase states
	// Only masked channels take the new code; others keep theirs
	always_ff @(posedge I_CLOCK) begin
		for (int k = 0; k < NCH; k++) begin
			if (I_SYS_RST) begin
				code_r[k] <= `CWQ_CODE_RST;
				en_r[k]   <= 1'b0;
			end else if (wr_stb && wr_addr == `CWQ_OFS_PHASE_SEL && mask_r[k]) begin
				code_r[k] <= wr_data[`CWQ_CODE_MSB:0];
				en_r[k]   <= wr_data[`CWQ_EN_BIT];
			end
		end
	end

	// step leads 22.5 degrees
	// Code drives the analog rotator; all channels share one LO
	always_comb begin
		for (int k = 0; k < NCH; k++) begin
			O_CH_CODE[4*k +: 4] = code_r[k];
		end
	end

	assign O_CH_EN = en_r;
	assign O_LO_I  = lo_i;
	assign O_LO_Q  = lo_q;

	// Helper: oscillator rises counted while I is high
	logic [2:0] hi_rises_r;
	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST || div_hold || !lo_i) begin
			hi_rises_r <= 3'h0;
		end else if (osc_rise) begin
			hi_rises_r <= hi_rises_r + 3'h1;
		end
	end

	// Helper: armed by any hold, cleared by the first oscillator rise after it
	logic first_rise_r;
	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST || div_hold) begin
			first_rise_r <= 1'b1;
		end else if (osc_rise) begin
			first_rise_r <= 1'b0;
		end
	end

	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (I_SYS_RST);

	property p_div_step;
		osc_rise && !div_hold |=> cnt == $past(cnt) + 2'h1;
	endproperty
	a_div_step: assert property (p_div_step) else $error("divider did not advance");

	property p_duty;
		$fell(lo_i) && !$past(div_hold) && !div_hold |-> $past(hi_rises_r) == 3'h1;
	endproperty
	a_duty: assert property (p_duty) else $error("I high not two osc periods");

	property p_retime;
		!$past(osc_rise) && !$past(div_hold) |-> $stable(lo_i) && $stable(lo_q);
	endproperty
	a_retime: assert property (p_retime) else $error("LO changed off an osc edge");

	property p_code_wr;
		wr_stb && wr_addr == `CWQ_OFS_PHASE_SEL && mask_r[0]
			|=> O_CH_CODE[3:0] == $past(wr_data[3:0]);
	endproperty
	a_code_wr: assert property (p_code_wr) else $error("phase code not written");

	property p_code_keep;
		!(wr_stb && mask_r[1]) |=> $stable(O_CH_CODE[7:4]);
	endproperty
	a_code_keep: assert property (p_code_keep) else $error("unmasked code changed");

	property p_hold;
		div_hold |=> cnt == `CWQ_DIV_HOLD_CNT && !lo_i && !lo_q;
	endproperty
	a_hold: assert property (p_hold) else $error("divider not held");

	property p_resume;
		first_rise_r && !div_hold && osc_rise |=> cnt == `CWQ_DIV_FIRST_CNT && lo_i && !lo_q;
	endproperty
	a_resume: assert property (p_resume) else $error("bad first state after reset");

	property p_quad;
		osc_rise && !div_hold && lo_i && !lo_q |=> lo_i && lo_q;
	endproperty
	a_quad: assert property (p_quad) else $error("Q not one count after I");

	c_read:   cover property (sclk_rise && sp_r == SP_DATA && rd_r);
	c_write:  cover property (wr_stb && wr_addr == `CWQ_OFS_PHASE_SEL);
	c_resume: cover property ($fell(div_hold) ##[1:20] osc_rise);
endmodule : cwq_phase_select

// [tb/cwq_lo_src.sv]
`timescale 1ns/1ps
// Quad-rate oscillator source and array sync driver
module cwq_lo_src (
	input  wire logic       i_clk,
	input  wire logic       i_run,
	input  wire logic [3:0] i_hi,
	input  wire logic [3:0] i_lo,
	input  wire logic       i_sync,
	output logic            o_osc,
	output logic            o_div_rst
);
	logic [3:0] cnt_r; // Cycles spent in this phase
	logic       arm_r; // Sync pulse pending
	initial begin
		o_osc = 1'b0;
		o_div_rst = 1'b0;
		cnt_r = 4'h0;
		arm_r = 1'b0;
	end
	// one period pulse
	// Raised and dropped on osc falls, so setup to the next rise is a full low phase
	always @(negedge i_clk) begin
		if (!i_run) begin
			o_osc <= 1'b0;
			cnt_r <= 4'h0;
		end else if (cnt_r == (o_osc ? i_hi : i_lo) - 4'h1) begin
			cnt_r <= 4'h0;
			o_osc <= ~o_osc;
			if (o_osc) begin
				o_div_rst <= arm_r;
				arm_r <= 1'b0;
			end
		end else
			cnt_r <= cnt_r + 4'h1;
		// Late so a request on a fall is kept
		if (i_sync)
			arm_r <= 1'b1;
	end
endmodule : cwq_lo_src

// [tb/test_cwq_phase_select.sv]
`timescale 1ns/1ps
module test_cwq_phase_select;
	logic        clk = 1'b0, rst = 1'b1, sclk = 1'b0, cs_n = 1'b1, sdio_drv = 1'b0;
	logic        run = 1'b0, sync = 1'b0, mon_reg = 1'b0, mon_lo = 1'b0, lo_first;
	logic [3:0]  hi = 4'h3, lo = 4'h7; // Deliberately lopsided duty
	logic        osc, div_rst, sdo, sdo_oe, lo_i, lo_q;
	logic [31:0] ch_code, exp_code = 32'h0;
	logic [7:0]  ch_en, exp_en = 8'h00, mask = 8'hFF;
	logic [39:0] regq[$], loq[$], rdq[$]; // Expected notes
	logic [39:0] reg_prev, rd_val;
	logic [1:0]  lo_prev;
	int          n_errors = 0, tests_run = 0, lo_gap = 0, per;
	event        rd_ev;
	always #2 clk = ~clk;
	cwq_lo_src src (.i_clk(clk), .i_run(run), .i_hi(hi), .i_lo(lo), .i_sync(sync),
		.o_osc(osc), .o_div_rst(div_rst));
	// Shared data pin resolved from both drivers
	cwq_phase_select dut (.I_CLOCK(clk), .I_SYS_RST(rst), .I_QUAD_RATE_OSC_IN(osc),
		.I_DIV_RESET(div_rst), .I_SCLK(sclk), .I_CS_N(cs_n),
		.I_SDIO(sdo_oe ? sdo : sdio_drv), .O_SDIO(sdo), .O_SDIO_OE(sdo_oe), .O_LO_I(lo_i),
		.O_LO_Q(lo_q), .O_CH_CODE(ch_code), .O_CH_EN(ch_en));
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic conclude();
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude
	task automatic limit(input logic bad);
		if (bad) begin
			n_errors++;
			conclude();
		end
	endtask : limit
	// Frame of nbits; read bits taken late in each high phase
	task automatic spi_frame(input logic [15:0] frm, input int nbits, output logic [7:0] rd);
		rd = 8'h00;
		cs_n = 1'b0;
		repeat (4) @(negedge clk);
		for (int b = 15; b >= 16 - nbits; b--) begin
			sdio_drv = frm[b];
			repeat (4) @(negedge clk);
			sclk = 1'b1;
			repeat (6) @(negedge clk);
			if (b <= 8)
				rd = {rd[6:0], sdo & sdo_oe};
			sclk = 1'b0;
		end
		repeat (4) @(negedge clk);
		cs_n = 1'b1;
		repeat (4) @(negedge clk);
	endtask : spi_frame
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] x;
		spi_frame({1'b0, a, d}, 16, x);
	endtask : wr
	task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] x;
		rdq.push_back({32'h0, e});
		spi_frame({1'b1, a, 8'h00}, 16, x);
		rd_val = {32'h0, x};
		-> rd_ev;
	endtask : rd_chk
	// Model the masked update; a note only when outputs move
	task automatic wr_phase(input logic [7:0] d);
		logic [39:0] old;
		old = {exp_code, exp_en};
		for (int c = 0; c < 8; c++)
			if (mask[c]) begin
				exp_code[4*c+:4] = d[3:0];
				exp_en[c] = d[4];
			end
		if ({exp_code, exp_en} !== old)
			regq.push_back({exp_code, exp_en});
		wr(7'h2D, d);
	endtask : wr_phase
	// Any move with no note is a fault
	always @(negedge clk)
		if (mon_reg && {ch_code, ch_en} !== reg_prev) begin
			if (regq.size() == 0)
				check({ch_code, ch_en}, reg_prev);
			else
				check({ch_code, ch_en}, regq.pop_front());
			reg_prev = {ch_code, ch_en};
		end
	always @(rd_ev)
		check(rd_val, rdq.pop_front());
	// Every I/Q step lands one osc period after the last
	always @(negedge clk) begin
		lo_gap++;
		if (mon_lo && {lo_i, lo_q} !== lo_prev) begin
			if (!lo_first)
				check(lo_gap, per);
			if (loq.size() == 0)
				check({lo_i, lo_q}, lo_prev);
			else
				check({lo_i, lo_q}, loq.pop_front());
			lo_gap = 0;
			lo_first = 1'b0;
		end
		lo_prev = {lo_i, lo_q};
	end
	initial begin
		logic [7:0] d;
		void'($urandom(14));
		repeat (16) @(negedge clk);
		check({ch_code, ch_en}, 40'h0);
		check({lo_i, lo_q, sdo_oe}, 40'h0);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		reg_prev = {ch_code, ch_en};
		mon_reg = 1'b1;
		rd_chk(7'h04, 8'hFF);
		rd_chk(7'h2D, 8'h00);
		wr_phase(8'h13);
		// Every code once, on a random channel, junk in top bits
		for (int c = 0; c < 16; c++) begin
			mask = 8'h01 << ($urandom % 8);
			wr(7'h04, mask);
			d = 8'($urandom);
			d[3:0] = c[3:0];
			wr_phase(d);
			rd_chk(7'h2D, {3'h0, d[4:0]});
		end
		rd_chk(7'h10, 8'h00);
		wr(7'h7F, 8'hAA);
		mask = 8'hFF;
		wr(7'h04, mask);
		// Aborted frame must not write
		spi_frame({1'b0, 7'h2D, 8'h1F}, 10, d);
		for (int k = 0; k < 2; k++) begin
			hi = k ? 4'h6 : 4'h3;
			lo = k ? 4'h3 : 4'h7;
			per = int'(hi) + int'(lo);
			run = 1'b1;
			// Held across a whole fall so the source cannot miss it
			sync = 1'b1;
			repeat (2) @(negedge clk);
			sync = 1'b0;
			for (int i = 0; i < 99 && !div_rst; i++) @(negedge clk);
			limit(!div_rst);
			for (int i = 0; i < 99 && div_rst; i++) @(negedge clk);
			limit(div_rst);
			check({lo_i, lo_q}, 40'h0);
			for (int i = 0; i < 8; i++)
				loq.push_back({38'h0, ~i[1], i[1] ^ i[0]});
			lo_first = 1'b1;
			mon_lo = 1'b1;
			for (int i = 0; i < 200 && loq.size() > 0; i++) @(negedge clk);
			limit(loq.size() > 0);
			mon_lo = 1'b0;
		end
		run = 1'b0;
		repeat (20) @(negedge clk);
		check(regq.size() + rdq.size(), 40'h0);
		conclude();
	end
endmodule : test_cwq_phase_select
